// ==== core/sarseq_map.svh ====
// constants and operating summary of the conversion sequencer
// Summary of operation
// R1 - host raises convert strobe after acquisition; rising edge starts conversion
// R2 - open both sampling-node ground switches first, then ground the arrays
// R3 - fourteen trials MSB first, weights halving from half to 1/16384
// R4 - after last trial return to acquisition, form code, flag completion
// R5 - conversion timed by own clock, never by the serial shift clock
// R6 - straight binary 14-bit code: 0000 zero, 2000 mid, 3FFF top
// R7 - input above reference span saturates at all-ones code
// R8 - input below ground saturates at all-zeros code
// R9 - up to 250 kSPS; power down automatically between conversions
// R10 - result belongs to the conversion just completed, no pipeline
// R11 - a started conversion finishes whatever the strobe does later
// R12 - busy flag from strobe edge to last trial; edges ignored meanwhile
// R13 - trial decisions land in a work register; result updated at end
`ifndef SARSEQ_MAP_SVH
`define SARSEQ_MAP_SVH
`define SARSEQ_NBITS        14
`define SARSEQ_CODE_ZERO    14'h0000
`define SARSEQ_CODE_MID     14'h2000
`define SARSEQ_CODE_FULL    14'h3FFF
`define SARSEQ_CLK_HZ       50000000
`define SARSEQ_SETTLE_CYC   4'h2
`define SARSEQ_TRIAL_CYC    4'h4
`endif

// ==== core/sarseq_pkg.sv ====
// types of the conversion sequencer
package sarseq_pkg;
    typedef enum logic [4:0]
    {
        SARSEQ_ACQ    = 5'b0_0001,
        SARSEQ_OPENSW = 5'b0_0010,
        SARSEQ_GNDARR = 5'b0_0100,
        SARSEQ_TRIAL  = 5'b0_1000,
        SARSEQ_DONE   = 5'b1_0000
    } sarseq_state_t;
endpackage

// ==== core/sarseq_top.sv ====
// control logic of the 14-bit successive approximation sequencer
`include "sarseq_map.svh"
module sarseq_top
#(
    parameter int NBITS = `SARSEQ_NBITS
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // host strobe, asynchronous pin
    input  wire logic             convert_strobe,
    // analog front end
    input  wire logic             comp_high,
    input  wire logic             over_range,
    input  wire logic             under_range,
    output logic                  pos_sample_ground_switch,
    output logic                  neg_sample_ground_switch,
    output logic                  array_to_ground,
    output logic [NBITS-1:0]      dac_code,
    output logic                  power_up,
    // status and result
    output logic                  busy,
    output logic                  conv_done,
    output logic [NBITS-1:0]      result
);

    // register updates counted from edge E, where the detector fires:
    //   E        busy and power up set, both ground switches open
    //   E+4      arrays leave the inputs and go to ground
    //   E+7      first trial code on the dac, msb set
    //   E+76     last decision taken
    //   E+77     result, completion pulse, back to acquiring
    // a conversion is about 80 clocks, 1.6 us at 50 MHz, well inside
    // the 4 us period of the top sample rate
    // limitation: the strobe edge is seen two to three clocks late, so
    // the sampling instant trails the pin and jitters by one clock

    ////////////////////////////////////////////////////////////////////////
    sarseq_pkg::sarseq_state_t state_reg;
    logic [2:0]       strobe_sync_reg;
    logic [3:0]       wait_reg;
    logic [NBITS-1:0] trial_bit_reg;
    logic [NBITS-1:0] work_reg;
    logic             strobe_rise;

    ////////////////////////////////////////////////////////////////////////
    // state decodes; is_acquiring is read by several output registers, is_grounded by array_to_ground only
    function automatic logic is_acquiring
    (
        input sarseq_pkg::sarseq_state_t cur
    );
        return cur == sarseq_pkg::SARSEQ_ACQ;
    endfunction

    // arrays sit on ground from the grounding step through the last trial
    function automatic logic is_grounded
    (
        input sarseq_pkg::sarseq_state_t cur
    );
        return cur == sarseq_pkg::SARSEQ_GNDARR
            || cur == sarseq_pkg::SARSEQ_TRIAL;
    endfunction

    // one step of the settle and trial timers, never wraps below zero
    function automatic logic [3:0] count_down
    (
        input logic [3:0] cnt
    );
        return (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
    endfunction

    // second and third stages feed the edge detector, first stage stays clean
    always_ff @(posedge clk)
    begin
        if (!nrst)
            strobe_sync_reg <= 3'h0;
        else
            strobe_sync_reg <= {strobe_sync_reg[1:0], convert_strobe};
    end
    assign strobe_rise = strobe_sync_reg[1] & ~strobe_sync_reg[2]; // [R1]

    ////////////////////////////////////////////////////////////////////////
    // sequence; runs on clk alone, the shift clock plays no part [R5]
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_reg     <= sarseq_pkg::SARSEQ_ACQ;
            wait_reg      <= 4'h0;
            trial_bit_reg <= '0;
            work_reg      <= '0;
        end
        else
        begin
            case (state_reg)
                sarseq_pkg::SARSEQ_ACQ:
                begin
                    // edges only count here, so later ones are ignored [R12]
                    if (strobe_rise) // [R1]
                    begin
                        state_reg <= sarseq_pkg::SARSEQ_OPENSW;
                        wait_reg  <= `SARSEQ_SETTLE_CYC;
                    end
                end
                sarseq_pkg::SARSEQ_OPENSW:
                begin
                    // switches open before arrays leave inputs [R2]
                    if (wait_reg == 4'h0)
                    begin
                        state_reg <= sarseq_pkg::SARSEQ_GNDARR;
                        wait_reg  <= `SARSEQ_SETTLE_CYC;
                    end
                    else
                        wait_reg <= count_down(wait_reg);
                end
                sarseq_pkg::SARSEQ_GNDARR:
                begin
                    if (wait_reg == 4'h0)
                    begin
                        state_reg     <= sarseq_pkg::SARSEQ_TRIAL;
                        wait_reg      <= `SARSEQ_TRIAL_CYC;
                        trial_bit_reg <= {1'b1, {(NBITS-1){1'b0}}}; // [R3]
                        work_reg      <= '0;
                    end
                    else
                        wait_reg <= count_down(wait_reg);
                end
                sarseq_pkg::SARSEQ_TRIAL:
                begin
                    if (wait_reg == 4'h0)
                    begin
                        // keep bit when comparator says input is above [R13]
                        if (comp_high)
                            work_reg <= work_reg | trial_bit_reg;
                        trial_bit_reg <= trial_bit_reg >> 1; // [R3]
                        wait_reg      <= `SARSEQ_TRIAL_CYC;
                        if (trial_bit_reg[0])
                            state_reg <= sarseq_pkg::SARSEQ_DONE;
                    end
                    else
                        wait_reg <= count_down(wait_reg);
                end
                sarseq_pkg::SARSEQ_DONE:
                    state_reg <= sarseq_pkg::SARSEQ_ACQ; // [R4]
                default:
                    state_reg <= sarseq_pkg::SARSEQ_ACQ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // front-end controls; ground switches closed only while acquiring
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pos_sample_ground_switch <= 1'b1;
            neg_sample_ground_switch <= 1'b1;
            array_to_ground          <= 1'b0;
            dac_code                 <= '0;
            power_up                 <= 1'b0;
            busy                     <= 1'b0;
        end
        else
        begin
            pos_sample_ground_switch <= is_acquiring(state_reg)
                                        && !strobe_rise; // [R2]
            neg_sample_ground_switch <= is_acquiring(state_reg)
                                        && !strobe_rise; // [R2]
            array_to_ground <= is_grounded(state_reg); // [R2]
            // trial code = kept bits plus bit under test [R3]
            dac_code <= (state_reg == sarseq_pkg::SARSEQ_TRIAL)
                        ? (work_reg | trial_bit_reg) : '0;
            // analog core idle outside the sequence saves power [R9]
            power_up <= !is_acquiring(state_reg) || strobe_rise;
            busy     <= state_reg != sarseq_pkg::SARSEQ_ACQ
                        && state_reg != sarseq_pkg::SARSEQ_DONE
                        || strobe_rise; // [R12] [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // visible result changes only at the end, from this very sample [R10]
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            result <= `SARSEQ_CODE_ZERO;
        end
        else
        begin
            if (state_reg == sarseq_pkg::SARSEQ_DONE)
            begin
                // range flags override, no wrap at either end [R6]
                if (over_range)
                    result <= `SARSEQ_CODE_FULL; // [R7]
                else if (under_range)
                    result <= `SARSEQ_CODE_ZERO; // [R8]
                else
                    result <= work_reg; // [R13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion pulse, one clock wide, in step with the new result
    always_ff @(posedge clk)
    begin
        if (!nrst)
            conv_done <= 1'b0;
        else
            conv_done <= state_reg == sarseq_pkg::SARSEQ_DONE; // [R4]
    end

endmodule // sarseq_top

// ==== bench/sarseq_host_model.sv ====
// host and comparator model standing at the far side of the sequencer
module sarseq_host_model
(
    // clock and bench requests
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic        glitch,
    input  wire logic        busy,
    // sampled input and trial code
    input  wire logic [13:0] vin,
    input  wire logic [13:0] dac_code,
    output logic             convert_strobe = 1'b0,
    output logic             comp_high
);
    // a tie keeps the bit, so an exact match lands on its own code
    assign comp_high = (vin >= dac_code);
    // strobe rises only on request; toggles in mid-conversion on demand
    always @(posedge clk)
        convert_strobe <= (glitch && busy) ? ~convert_strobe : start;
endmodule // sarseq_host_model

// ==== bench/sarseq_top_assertions.sv ====
// port assertions of the conversion sequencer
module sarseq_checker
#(
    parameter int NBITS = 14
)
(
    // clock, reset and inputs
    input wire logic             clk, nrst, convert_strobe, comp_high,
    input wire logic             over_range, under_range,
    // outputs
    input wire logic             pos_sample_ground_switch,
    input wire logic             neg_sample_ground_switch, array_to_ground,
    input wire logic [NBITS-1:0] dac_code, result,
    input wire logic             power_up, busy, conv_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    open_first_a: assert property ($rose(busy) |-> !pos_sample_ground_switch
        && !neg_sample_ground_switch && !array_to_ground ##4 array_to_ground)
        else $error("switch order");
    msb_first_a: assert property ($rose(array_to_ground) |-> ##[0:5]
        dac_code == 14'h2000) else $error("first trial not msb");
    conv_length_a: assert property ($rose(busy) |-> ##[70:90] conv_done)
        else $error("conversion length");
    done_follow_a: assert property ($fell(busy) |-> conv_done)
        else $error("no completion");
    power_down_a: assert property (conv_done |=> !power_up)
        else $error("still powered");
    result_hold_a: assert property ($changed(result) |-> conv_done)
        else $error("result moved");
    over_clamp_a: assert property (conv_done && $past(over_range) |->
        result == 14'h3FFF) else $error("over clamp");
    under_clamp_a: assert property (conv_done && $past(under_range) &&
        !$past(over_range) |-> result == 14'h0000) else $error("under clamp");
endmodule // sarseq_checker
bind sarseq_top sarseq_checker #(.NBITS(NBITS)) sarseq_checker_inst (.*);

// ==== bench/tb_sarseq_top.sv ====
// self-checking bench of the conversion sequencer
module tb_sarseq_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, nrst = 0, start = 0, glitch = 0;
    logic        over_range = 0, under_range = 0, convert_strobe, comp_high;
    logic        pos_sample_ground_switch, neg_sample_ground_switch;
    logic        array_to_ground, power_up, busy, conv_done;
    logic [13:0] vin = 0, dac_code, result;
    logic [31:0] rng = 32'h0000_0008;
    int          errors = 0, samples_checked = 0, n;
    ////////////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    sarseq_host_model sarseq_host_model_inst (.clk, .start, .glitch, .busy,
        .vin, .dac_code, .convert_strobe, .comp_high);
    sarseq_top sarseq_top_inst (.clk, .nrst, .convert_strobe, .comp_high,
        .over_range, .under_range, .pos_sample_ground_switch,
        .neg_sample_ground_switch, .array_to_ground, .dac_code, .power_up,
        .busy, .conv_done, .result);
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check14(string what, logic [13:0] exp, logic [13:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s exp %h got %h", what, exp, got);
        end
    endtask
    function logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // over-range wins when both range flags are up
    function logic [13:0] expect_code(logic [13:0] v, logic o, logic u);
        return o ? 14'h3FFF : (u ? 14'h0000 : v);
    endfunction
    // bounded wait; running out ends the run as a failure
    task automatic wait_for(ref logic sig);
        for (n = 0; n < 200 && sig !== 1'b1; n++) @(negedge clk);
        if (n == 200)
        begin
            errors++;
            close_out();
        end
    endtask
    // range levels stay put for the whole conversion
    task convert(logic [13:0] v, logic o, logic u, logic g);
        @(negedge clk);
        {vin, over_range, under_range, glitch, start} = {v, o, u, g, 1'b1};
        wait_for(busy);
        repeat (20) @(negedge clk);
        glitch = 0;
        wait_for(conv_done);
        check14("result", expect_code(v, o, u), result);
        @(negedge clk);
        check14("switches", 14'h0003, {busy, pos_sample_ground_switch,
            neg_sample_ground_switch});
        start = 0;
        repeat (6) @(negedge clk);
        check14("idle", 14'h0000, {busy, power_up});
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        nrst = 1;
        check14("reset", 14'h0000, result);
        convert(14'h0000, 0, 0, 0);
        convert(14'h2000, 0, 0, 1);
        convert(14'h3FFF, 0, 0, 0);
        convert(14'h1234, 1, 0, 0);
        convert(14'h2001, 0, 1, 1);
        convert(14'h0001, 1, 1, 0);
        for (int i = 0; i < 8; i++)
        begin
            rng = xs(rng);
            convert(rng[13:0], 0, 0, rng[20]);
        end
        close_out();
    end
endmodule // tb_sarseq_top
